// ### rtl/tcpp_regs.svh
`ifndef TCPP_REGS_SVH
`define TCPP_REGS_SVH
// ****************************************************************
// Register offsets (byte addresses, one word each)
// ****************************************************************
`define TCPP_OFF_ALERT_MASK 8'h0C
`define TCPP_OFF_CONN_CODE 8'h0E
`define TCPP_OFF_PORT_STATE 8'h11
`define TCPP_OFF_ADVERTISE 8'h18
`define TCPP_OFF_CABLE_ILIM 8'h1E
`define TCPP_OFF_CABLE_MON 8'h20
`define TCPP_OFF_WINDOW 8'h22
`define TCPP_OFF_SOFT_RESET 8'h23
`define TCPP_OFF_DRAIN_TIME 8'h25
`define TCPP_OFF_ROLE 8'h28
`define TCPP_OFF_MONITOR_CTL 8'h2E
`define TCPP_OFF_DRAIN_CTL 8'h30
`define TCPP_OFF_SINK_CURRENT 8'h34
// ****************************************************************
// Reset values
// ****************************************************************
`define TCPP_RST_ALERT_MASK 3'h7
`define TCPP_RST_ADVERTISE 4'h4
`define TCPP_RST_CABLE_ILIM 4'h0
`define TCPP_RST_CABLE_MON 2'h1
`define TCPP_RST_WINDOW 16'hF757
`define TCPP_RST_SOFT_RESET 1'h0
`define TCPP_RST_DRAIN_TIME 4'hA
`define TCPP_RST_ROLE 3'h3
`define TCPP_RST_MONITOR_CTL 5'h04
`define TCPP_RST_DRAIN_CTL 2'h0
// ****************************************************************
// Codes and timing
// ****************************************************************
`define TCPP_ROLE_SINK 3'h1
`define TCPP_ROLE_DUAL 3'h3
`define TCPP_CODE_NONE 8'h00
`define TCPP_CODE_SRC 8'h2D
`define TCPP_CODE_SRC_VCONN 8'h2F
`define TCPP_CODE_SRC_DBG 8'h6D
`define TCPP_CODE_SNK 8'h41
`define TCPP_CODE_SNK_DBG 8'h61
`define TCPP_CODE_AUDIO 8'h81
`define TCPP_TOGGLE_US 50
`define TCPP_CLK_MHZ 40
`define TCPP_TOGGLE_CYC (`TCPP_TOGGLE_US * `TCPP_CLK_MHZ)
`endif

// ### rtl/tcpp_pkg.sv
package tcpp_pkg;
  // Termination seen on one CC line
  typedef enum logic [2:0] {
    TCPP_OPEN = 3'h0,
    TCPP_RA = 3'h1,
    TCPP_RD = 3'h2,
    TCPP_RP_DEF = 3'h3,
    TCPP_RP_1A5 = 3'h4,
    TCPP_RP_3A = 3'h5
  } tcpp_term_t;
  // Port states, Gray along the dual-role unattached toggle path
  typedef enum logic [3:0] {
    TCPP_UNATT_SNK = 4'h0,
    TCPP_UNATT_SRC = 4'h1,
    TCPP_UNATT_ACC = 4'h3,
    TCPP_ATT_SRC = 4'h2,
    TCPP_ATT_SNK = 4'h6,
    TCPP_DBG_SRC_UNOR = 4'h7,
    TCPP_DBG_SRC_OR = 4'h5,
    TCPP_DBG_SNK = 4'h4,
    TCPP_AUDIO = 4'hC
  } tcpp_state_t;
endpackage : tcpp_pkg

// ### rtl/tcpp_sync.sv
`timescale 1ns/1ps
module tcpp_sync (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic en_in,
  input wire logic [8:0] d_in,
  output logic [8:0] q_out
);
  logic [8:0] s1_q;
  // Two stages, first stage read only by the second
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_q <= 9'h000;
      q_out <= 9'h000;
    end else if (en_in) begin
      s1_q <= d_in;
      q_out <= s1_q;
    end
  end
endmodule : tcpp_sync

// ### rtl/tcpp_wb.sv
`timescale 1ns/1ps
`include "tcpp_regs.svh"
module tcpp_wb (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic en_in,
  input wire logic cyc_in,
  input wire logic stb_in,
  input wire logic we_in,
  input wire logic [3:0] sel_in,
  output logic ack_out,
  output logic wr_out,
  output logic rd_out
);
  // One-wait-state classic slave: ack one cycle after stb, dropped next
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_out <= 1'b0;
    end else if (en_in) begin
      ack_out <= cyc_in && stb_in && !ack_out;
    end
  end
  assign wr_out = en_in && ack_out && we_in && sel_in[0];
  assign rd_out = ack_out && !we_in;
endmodule : tcpp_wb

// ### rtl/tcpp_top.sv
// Added by the designer: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`include "tcpp_regs.svh"
// What this block does
// - Sink enable needs sink attach and bus valid
// - Enables release when any condition fails
// - Source enable needs source attach, bus, supply
// - Nothing attached: toggle, code 00h, all off
// - Rd plus open: Attached source, 2Dh
// - Orientation low when termination on CC2
// - Rd plus Ra: source, 2Fh, cable power
// - Ra alone causes no attach
// - Rd both: unoriented source debug, 6Dh
// - Oriented source debug (6Dh) decoded, never entered
// - Ra both: audio accessory, 81h, off
// - Rp plus open/Ra: Attached sink, 41h
// - Sink debug orientation follows stronger pull-up
// - Sink-only ignores Rd/Rd and Rd/Ra
// - Three alert masks reset to masked
// - Port role resets to dual with accessory
// - Drain time 1010b, drain path enabled
// - Source window shifts 0111b and 0101b
// - Sink window shifts 0111b and 1111b
// - Cable limit 0000b, monitor on, high level
// - Advertise default, cable supply on, standby off
// - Supply/bus checks defaults, safe-zero 00b
// - Reset from pin only by default
// - Bus enables are open-drain active low
module tcpp_top (
  input wire logic CLOCK_IN,
  input wire logic RESETN_IN,
  input wire logic CLK_EN_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  input wire logic [2:0] CC1_TERM_IN,
  input wire logic [2:0] CC2_TERM_IN,
  input wire logic BUS_VOLTAGE_SENSE_IN,
  input wire logic HV_SUPPLY_PRESENT_IN,
  input wire logic HV_SUPPLY_OVERVOLT_IN,
  output logic SINK_POWER_ENABLE_N_OUT,
  output logic SINK_POWER_ENABLE_OE_OUT,
  output logic SOURCE_POWER_ENABLE_N_OUT,
  output logic SOURCE_POWER_ENABLE_OE_OUT,
  output logic ORIENTATION_OUT,
  output logic ORIENTATION_OE_OUT,
  output logic VCONN_CC1_OUT,
  output logic VCONN_CC2_OUT,
  output logic [1:0] SINK_CURRENT_OUT,
  output logic SOFT_RESET_REQ_OUT
);
  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [8:0] pin_s;
  tcpp_sync u_sync (
    .clk_in(CLOCK_IN),
    .rst_n_in(RESETN_IN),
    .en_in(CLK_EN_IN),
    .d_in({CC1_TERM_IN, CC2_TERM_IN, BUS_VOLTAGE_SENSE_IN, HV_SUPPLY_PRESENT_IN,
      HV_SUPPLY_OVERVOLT_IN}),
    .q_out(pin_s)
  );
  tcpp_pkg::tcpp_term_t cc1, cc2;
  logic bus_ok_raw, hv_present, hv_over;
  assign cc1 = tcpp_pkg::tcpp_term_t'(pin_s[8:6]);
  assign cc2 = tcpp_pkg::tcpp_term_t'(pin_s[5:3]);
  assign bus_ok_raw = pin_s[2];
  assign hv_present = pin_s[1];
  assign hv_over = pin_s[0];
  // ****************************************************************
  // Bus slave
  // ****************************************************************
  logic wr_stb;
  tcpp_wb u_wb (
    .clk_in(CLOCK_IN),
    .rst_n_in(RESETN_IN),
    .en_in(CLK_EN_IN),
    .cyc_in(WB_CYC_IN),
    .stb_in(WB_STB_IN),
    .we_in(WB_WE_IN),
    .sel_in(WB_SEL_IN),
    .ack_out(WB_ACK_OUT),
    .wr_out(wr_stb),
    .rd_out()
  );
  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  logic [2:0] alert_mask_q;
  logic [3:0] advertise_q;
  logic [3:0] cable_power_current_limit_q;
  logic [1:0] cable_mon_q;
  logic [15:0] window_q;
  logic soft_reset_select_q;
  logic [3:0] bus_drain_time_sel_q;
  logic [2:0] port_role_sel_q;
  logic [4:0] monitor_ctl_q;
  logic [1:0] drain_ctl_q;
  logic [7:0] wadr;
  assign wadr = WB_ADR_IN;
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      alert_mask_q <= `TCPP_RST_ALERT_MASK;
      advertise_q <= `TCPP_RST_ADVERTISE;
      cable_power_current_limit_q <= `TCPP_RST_CABLE_ILIM;
      cable_mon_q <= `TCPP_RST_CABLE_MON;
      window_q <= `TCPP_RST_WINDOW;
      soft_reset_select_q <= `TCPP_RST_SOFT_RESET;
      bus_drain_time_sel_q <= `TCPP_RST_DRAIN_TIME;
      port_role_sel_q <= `TCPP_RST_ROLE;
      monitor_ctl_q <= `TCPP_RST_MONITOR_CTL;
      drain_ctl_q <= `TCPP_RST_DRAIN_CTL;
    end else if (wr_stb) begin
      case (wadr)
        `TCPP_OFF_ALERT_MASK: begin
          alert_mask_q <= WB_DAT_IN[2:0];
        end
        `TCPP_OFF_ADVERTISE: begin
          advertise_q <= WB_DAT_IN[3:0];
        end
        `TCPP_OFF_CABLE_ILIM: begin
          cable_power_current_limit_q <= WB_DAT_IN[3:0];
        end
        `TCPP_OFF_CABLE_MON: begin
          cable_mon_q <= WB_DAT_IN[1:0];
        end
        `TCPP_OFF_WINDOW: begin
          window_q <= WB_DAT_IN[15:0];
        end
        `TCPP_OFF_SOFT_RESET: begin
          soft_reset_select_q <= WB_DAT_IN[0];
        end
        `TCPP_OFF_DRAIN_TIME: begin
          bus_drain_time_sel_q <= WB_DAT_IN[3:0];
        end
        `TCPP_OFF_ROLE: begin
          port_role_sel_q <= WB_DAT_IN[2:0];
        end
        `TCPP_OFF_MONITOR_CTL: begin
          monitor_ctl_q <= WB_DAT_IN[4:0];
        end
        `TCPP_OFF_DRAIN_CTL: begin
          drain_ctl_q <= WB_DAT_IN[1:0];
        end
        default: begin
        end
      endcase
    end
  end
  // Soft reset request only honoured when software reset is selected
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      SOFT_RESET_REQ_OUT <= 1'b0;
    end else if (CLK_EN_IN) begin
      SOFT_RESET_REQ_OUT <= soft_reset_select_q && wr_stb && wadr == `TCPP_OFF_SOFT_RESET
        && WB_DAT_IN[1];
    end
  end
  // Range check inhibit forces bus valid; overvolt inhibit ignores supply
  logic bus_ok, hv_ok, sink_only;
  assign bus_ok = bus_ok_raw || monitor_ctl_q[1];
  assign hv_ok = !hv_present || !hv_over || monitor_ctl_q[0];
  assign sink_only = port_role_sel_q == `TCPP_ROLE_SINK;
  // ****************************************************************
  // Connection state machine
  // ****************************************************************
  tcpp_pkg::tcpp_state_t state_q, state_d;
  logic [11:0] toggle_q;
  logic toggle_done;
  assign toggle_done = toggle_q == 12'(`TCPP_TOGGLE_CYC - 1);
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      toggle_q <= 12'h000;
    end else if (CLK_EN_IN) begin
      toggle_q <= toggle_done ? 12'h000 : toggle_q + 12'h001;
    end
  end
  logic is_rd1, is_rd2, is_rp1, is_rp2, low1, low2;
  assign is_rd1 = cc1 == tcpp_pkg::TCPP_RD;
  assign is_rd2 = cc2 == tcpp_pkg::TCPP_RD;
  assign is_rp1 = cc1 >= tcpp_pkg::TCPP_RP_DEF;
  assign is_rp2 = cc2 >= tcpp_pkg::TCPP_RP_DEF;
  assign low1 = cc1 == tcpp_pkg::TCPP_OPEN || cc1 == tcpp_pkg::TCPP_RA;
  assign low2 = cc2 == tcpp_pkg::TCPP_OPEN || cc2 == tcpp_pkg::TCPP_RA;
  logic src_look, snk_look;
  assign src_look = state_q == tcpp_pkg::TCPP_UNATT_SRC && !sink_only;
  assign snk_look = state_q == tcpp_pkg::TCPP_UNATT_SNK || state_q == tcpp_pkg::TCPP_UNATT_ACC;
  always_comb begin
    state_d = state_q;
    case (state_q)
      tcpp_pkg::TCPP_UNATT_SNK, tcpp_pkg::TCPP_UNATT_SRC, tcpp_pkg::TCPP_UNATT_ACC: begin
        if (toggle_done) begin
          if (state_q != tcpp_pkg::TCPP_UNATT_SNK) begin
            state_d = tcpp_pkg::TCPP_UNATT_SNK;
          end else if (sink_only) begin
            state_d = tcpp_pkg::TCPP_UNATT_ACC;
          end else begin
            state_d = tcpp_pkg::TCPP_UNATT_SRC;
          end
        end
        if (cc1 == tcpp_pkg::TCPP_RA && cc2 == tcpp_pkg::TCPP_RA) begin
          state_d = tcpp_pkg::TCPP_AUDIO;
        end else if (is_rp1 && is_rp2 && snk_look) begin
          state_d = tcpp_pkg::TCPP_DBG_SNK;
        end else if (((is_rp1 && low2) || (is_rp2 && low1)) && snk_look) begin
          state_d = tcpp_pkg::TCPP_ATT_SNK;
        end else if (src_look && is_rd1 && is_rd2) begin
          state_d = tcpp_pkg::TCPP_DBG_SRC_UNOR;
        end else if (src_look && ((is_rd1 && cc2 == tcpp_pkg::TCPP_OPEN)
            || (is_rd2 && cc1 == tcpp_pkg::TCPP_OPEN) || (is_rd1 && cc2 == tcpp_pkg::TCPP_RA)
            || (is_rd2 && cc1 == tcpp_pkg::TCPP_RA))) begin
          state_d = tcpp_pkg::TCPP_ATT_SRC;
        end
      end
      tcpp_pkg::TCPP_ATT_SRC: begin
        if (!((is_rd1 && low2) || (is_rd2 && low1))) begin
          state_d = tcpp_pkg::TCPP_UNATT_SNK;
        end
      end
      tcpp_pkg::TCPP_DBG_SRC_UNOR: begin
        if (!(is_rd1 && is_rd2)) begin
          state_d = tcpp_pkg::TCPP_UNATT_SNK;
        end
      end
      tcpp_pkg::TCPP_ATT_SNK: begin
        if (!((is_rp1 && low2) || (is_rp2 && low1))) begin
          state_d = tcpp_pkg::TCPP_UNATT_SNK;
        end
      end
      tcpp_pkg::TCPP_DBG_SNK: begin
        if (!(is_rp1 && is_rp2)) begin
          state_d = tcpp_pkg::TCPP_UNATT_SNK;
        end
      end
      tcpp_pkg::TCPP_AUDIO: begin
        if (!(cc1 == tcpp_pkg::TCPP_RA && cc2 == tcpp_pkg::TCPP_RA)) begin
          state_d = tcpp_pkg::TCPP_UNATT_SNK;
        end
      end
      default: begin
        state_d = tcpp_pkg::TCPP_UNATT_SNK;
      end
    endcase
  end
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      state_q <= tcpp_pkg::TCPP_UNATT_SNK;
    end else if (CLK_EN_IN) begin
      state_q <= state_d;
    end
  end
  // ****************************************************************
  // Outputs, registered except the constant open-drain data lines
  // ****************************************************************
  logic [7:0] code_d;
  logic src_att, snk_att, orient_cc2, vconn1, vconn2;
  logic [1:0] cur_d;
  always_comb begin
    code_d = `TCPP_CODE_NONE;
    src_att = 1'b0;
    snk_att = 1'b0;
    orient_cc2 = 1'b0;
    vconn1 = 1'b0;
    vconn2 = 1'b0;
    cur_d = 2'h0;
    case (state_q)
      tcpp_pkg::TCPP_ATT_SRC: begin
        src_att = 1'b1;
        orient_cc2 = is_rd2;
        if (cc1 == tcpp_pkg::TCPP_RA || cc2 == tcpp_pkg::TCPP_RA) begin
          code_d = `TCPP_CODE_SRC_VCONN;
          vconn1 = cc1 == tcpp_pkg::TCPP_RA && advertise_q[2];
          vconn2 = cc2 == tcpp_pkg::TCPP_RA && advertise_q[2];
        end else begin
          code_d = `TCPP_CODE_SRC;
        end
      end
      tcpp_pkg::TCPP_DBG_SRC_UNOR: begin
        src_att = 1'b1;
        code_d = `TCPP_CODE_SRC_DBG;
      end
      tcpp_pkg::TCPP_DBG_SRC_OR: begin
        src_att = 1'b1;
        orient_cc2 = is_rd2;
        code_d = `TCPP_CODE_SRC_DBG;
      end
      tcpp_pkg::TCPP_ATT_SNK: begin
        snk_att = 1'b1;
        orient_cc2 = is_rp2;
        code_d = `TCPP_CODE_SNK;
      end
      tcpp_pkg::TCPP_DBG_SNK: begin
        snk_att = 1'b1;
        code_d = `TCPP_CODE_SNK_DBG;
        orient_cc2 = cc2 > cc1;
        if (cc1 == tcpp_pkg::TCPP_RP_DEF || cc2 == tcpp_pkg::TCPP_RP_DEF) begin
          if (cc1 == tcpp_pkg::TCPP_RP_1A5 || cc2 == tcpp_pkg::TCPP_RP_1A5) begin
            cur_d = 2'h1;
          end else if (cc1 == tcpp_pkg::TCPP_RP_3A || cc2 == tcpp_pkg::TCPP_RP_3A) begin
            cur_d = 2'h2;
          end
        end
      end
      tcpp_pkg::TCPP_AUDIO: begin
        code_d = `TCPP_CODE_AUDIO;
      end
      default: begin
      end
    endcase
  end
  logic [7:0] code_q;
  logic [3:0] state_rep_q;
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      code_q <= `TCPP_CODE_NONE;
      state_rep_q <= 4'h0;
      SINK_POWER_ENABLE_OE_OUT <= 1'b0;
      SOURCE_POWER_ENABLE_OE_OUT <= 1'b0;
      ORIENTATION_OE_OUT <= 1'b0;
      VCONN_CC1_OUT <= 1'b0;
      VCONN_CC2_OUT <= 1'b0;
      SINK_CURRENT_OUT <= 2'h0;
    end else if (CLK_EN_IN) begin
      code_q <= code_d;
      state_rep_q <= state_q;
      SINK_POWER_ENABLE_OE_OUT <= snk_att && bus_ok;
      SOURCE_POWER_ENABLE_OE_OUT <= src_att && bus_ok && hv_ok;
      ORIENTATION_OE_OUT <= orient_cc2;
      VCONN_CC1_OUT <= vconn1;
      VCONN_CC2_OUT <= vconn2;
      SINK_CURRENT_OUT <= cur_d;
    end
  end
  // Open drain: only ever pull low, released otherwise
  assign SINK_POWER_ENABLE_N_OUT = 1'b0;
  assign SOURCE_POWER_ENABLE_N_OUT = 1'b0;
  assign ORIENTATION_OUT = 1'b0;
  // ****************************************************************
  // Read mux
  // ****************************************************************
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      WB_DAT_OUT <= 32'h0000_0000;
    end else if (CLK_EN_IN) begin
      case (wadr)
        `TCPP_OFF_ALERT_MASK: WB_DAT_OUT <= {29'h0, alert_mask_q};
        `TCPP_OFF_CONN_CODE: WB_DAT_OUT <= {24'h0, code_q};
        `TCPP_OFF_PORT_STATE: WB_DAT_OUT <= {28'h0, state_rep_q};
        `TCPP_OFF_ADVERTISE: WB_DAT_OUT <= {28'h0, advertise_q};
        `TCPP_OFF_CABLE_ILIM: WB_DAT_OUT <= {28'h0, cable_power_current_limit_q};
        `TCPP_OFF_CABLE_MON: WB_DAT_OUT <= {30'h0, cable_mon_q};
        `TCPP_OFF_WINDOW: WB_DAT_OUT <= {16'h0, window_q};
        `TCPP_OFF_SOFT_RESET: WB_DAT_OUT <= {31'h0, soft_reset_select_q};
        `TCPP_OFF_DRAIN_TIME: WB_DAT_OUT <= {28'h0, bus_drain_time_sel_q};
        `TCPP_OFF_ROLE: WB_DAT_OUT <= {29'h0, port_role_sel_q};
        `TCPP_OFF_MONITOR_CTL: WB_DAT_OUT <= {27'h0, monitor_ctl_q};
        `TCPP_OFF_DRAIN_CTL: WB_DAT_OUT <= {30'h0, drain_ctl_q};
        `TCPP_OFF_SINK_CURRENT: WB_DAT_OUT <= {30'h0, SINK_CURRENT_OUT};
        default: WB_DAT_OUT <= 32'h0000_0000;
      endcase
    end
  end
endmodule : tcpp_top

// ### dv/tcpp_top_assertions.sv
`timescale 1ns/1ps
module tcpp_top_chk (
  input wire logic CLOCK_IN,
  input wire logic RESETN_IN,
  input wire logic CLK_EN_IN,
  input wire logic BUS_VOLTAGE_SENSE_IN,
  input wire logic HV_SUPPLY_PRESENT_IN,
  input wire logic HV_SUPPLY_OVERVOLT_IN,
  input wire logic [2:0] CC1_TERM_IN,
  input wire logic [2:0] CC2_TERM_IN,
  input wire logic SINK_POWER_ENABLE_N_OUT,
  input wire logic SINK_POWER_ENABLE_OE_OUT,
  input wire logic SOURCE_POWER_ENABLE_N_OUT,
  input wire logic SOURCE_POWER_ENABLE_OE_OUT,
  input wire logic ORIENTATION_OUT,
  input wire logic ORIENTATION_OE_OUT,
  input wire logic VCONN_CC1_OUT,
  input wire logic VCONN_CC2_OUT
);
  logic snk, src, any_on, idle_cc, ra_only, ra_pair;
  assign snk = SINK_POWER_ENABLE_OE_OUT;
  assign src = SOURCE_POWER_ENABLE_OE_OUT;
  assign any_on = snk | src | VCONN_CC1_OUT | VCONN_CC2_OUT;
  assign idle_cc = ({CC1_TERM_IN, CC2_TERM_IN} == 6'h00);
  assign ra_only = ({CC1_TERM_IN, CC2_TERM_IN} == 6'h08) || ({CC1_TERM_IN, CC2_TERM_IN} == 6'h01);
  assign ra_pair = ({CC1_TERM_IN, CC2_TERM_IN} == 6'h09);
  default clocking cb @(posedge CLOCK_IN); endclocking
  // Frozen clock enable holds every output, so no check runs then
  default disable iff (!RESETN_IN || !CLK_EN_IN);
  // Sync plus update is three edges, so four samples are the minimum, with no margin
  chk_bus_drop: assert property (
    (!BUS_VOLTAGE_SENSE_IN) [*4] |-> !snk && !src)
    else $error("Power enable held with bus out of range");
  chk_hv_lockout: assert property (
    (HV_SUPPLY_PRESENT_IN && HV_SUPPLY_OVERVOLT_IN) [*4] |-> !src)
    else $error("Source enable held above supply lockout");
  chk_one_role: assert property (
    !(snk && src))
    else $error("Sink and source enables both asserted");
  chk_od_low: assert property (
    {SINK_POWER_ENABLE_N_OUT, SOURCE_POWER_ENABLE_N_OUT, ORIENTATION_OUT} == 3'h0)
    else $error("Open-drain data line not low");
  chk_idle_off: assert property (
    idle_cc [*6] |-> !any_on && !ORIENTATION_OE_OUT)
    else $error("Output active with both lines open");
  chk_cable_only: assert property (
    ra_only [*6] |-> !any_on)
    else $error("Lone cable termination caused an attach");
  chk_audio_off: assert property (
    ra_pair [*6] |-> !any_on)
    else $error("Power or cable supply on in audio state");
  chk_vconn_side: assert property (
    (!VCONN_CC1_OUT || $past(CC1_TERM_IN, 4) == 3'h1) &&
    (!VCONN_CC2_OUT || $past(CC2_TERM_IN, 4) == 3'h1))
    else $error("Cable power routed to a line without Ra");
  chk_orient_cc2: assert property (
    ORIENTATION_OE_OUT |-> $past(CC2_TERM_IN, 4) inside {3'h2, 3'h3, 3'h4, 3'h5})
    else $error("Orientation low without active term on CC2");
  cov_src_flip: cover property (src && ORIENTATION_OE_OUT);
  cov_snk_on: cover property (snk);
  cov_vconn2: cover property (VCONN_CC2_OUT);
endmodule : tcpp_top_chk

bind tcpp_top tcpp_top_chk u_chk (
  .CLOCK_IN(CLOCK_IN), .RESETN_IN(RESETN_IN), .BUS_VOLTAGE_SENSE_IN(BUS_VOLTAGE_SENSE_IN),
  .CLK_EN_IN(CLK_EN_IN),
  .HV_SUPPLY_PRESENT_IN(HV_SUPPLY_PRESENT_IN), .HV_SUPPLY_OVERVOLT_IN(HV_SUPPLY_OVERVOLT_IN),
  .CC1_TERM_IN(CC1_TERM_IN), .CC2_TERM_IN(CC2_TERM_IN),
  .SINK_POWER_ENABLE_N_OUT(SINK_POWER_ENABLE_N_OUT),
  .SINK_POWER_ENABLE_OE_OUT(SINK_POWER_ENABLE_OE_OUT),
  .SOURCE_POWER_ENABLE_N_OUT(SOURCE_POWER_ENABLE_N_OUT),
  .SOURCE_POWER_ENABLE_OE_OUT(SOURCE_POWER_ENABLE_OE_OUT),
  .ORIENTATION_OUT(ORIENTATION_OUT), .ORIENTATION_OE_OUT(ORIENTATION_OE_OUT),
  .VCONN_CC1_OUT(VCONN_CC1_OUT), .VCONN_CC2_OUT(VCONN_CC2_OUT));

// ### dv/tcpp_remote_port.sv
`timescale 1ns/1ps
module tcpp_remote_port (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [2:0] cc1_req_in,
  input wire logic [2:0] cc2_req_in,
  input wire logic [3:0] lag_in,
  output logic [2:0] cc1_out,
  output logic [2:0] cc2_out
);
  logic [2:0] cc1_q, cc2_q;
  logic [3:0] wait_q;
  // Lag models slow mating; both lines move together, never half-changed
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cc1_q <= 3'h0;
      cc2_q <= 3'h0;
      wait_q <= 4'h0;
    end else if ({cc1_req_in, cc2_req_in} == {cc1_q, cc2_q}) begin
      wait_q <= 4'h0;
    end else if (wait_q >= lag_in) begin
      cc1_q <= cc1_req_in;
      cc2_q <= cc2_req_in;
      wait_q <= 4'h0;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
  // Unplugged until reset ends, so the lines are never unknown
  assign cc1_out = rst_n_in ? cc1_q : 3'h0;
  assign cc2_out = rst_n_in ? cc2_q : 3'h0;
endmodule : tcpp_remote_port

// ### dv/test_tcpp_top.sv
`timescale 1ns/1ps
module test_tcpp_top;
  // ****
  // Signals
  // ****
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic en = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_w = 32'h0000_0000;
  logic [31:0] dat_r, q0, q1;
  logic ack, snk_n, snk_oe, src_n, src_oe, ori, ori_oe, vc1, vc2, srq;
  logic [1:0] cur;
  logic [2:0] cc1_req = 3'h0, cc2_req = 3'h0, cc1, cc2;
  logic [3:0] lag = 4'h0, rv;
  logic bus_ok = 1'b1, hv_p = 1'b0, hv_ov = 1'b0, srq_seen = 1'b0;
  logic [32:0] exp_q[$];
  int err_count = 0;
  int cmp_count = 0;
  // Case: cc1, cc2, code, {src, snk, orient, vconn1, vconn2, current}
  localparam logic [23:0] CASES [20] = '{
    24'h20_2D40, 24'h02_2D50, 24'h21_2F44, 24'h12_2F58, 24'h10_0000,
    24'h01_0000, 24'h22_6D40, 24'h11_8100, 24'h30_4120, 24'h15_4130,
    24'h54_6120, 24'h45_6130, 24'h43_6121, 24'h34_6131, 24'h53_6122,
    24'h35_6132, 24'h33_6120, 24'h22_0000, 24'h21_0000, 24'h30_4120};
  always #12.5 clk = ~clk;
  tcpp_remote_port u_far (.clk_in(clk), .rst_n_in(rst_n), .cc1_req_in(cc1_req),
    .cc2_req_in(cc2_req), .lag_in(lag), .cc1_out(cc1), .cc2_out(cc2));
  tcpp_top dut_u (.CLOCK_IN(clk), .RESETN_IN(rst_n), .CLK_EN_IN(en), .WB_CYC_IN(cyc),
    .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(dat_w),
    .WB_DAT_OUT(dat_r), .WB_ACK_OUT(ack), .CC1_TERM_IN(cc1), .CC2_TERM_IN(cc2),
    .BUS_VOLTAGE_SENSE_IN(bus_ok), .HV_SUPPLY_PRESENT_IN(hv_p), .HV_SUPPLY_OVERVOLT_IN(hv_ov),
    .SINK_POWER_ENABLE_N_OUT(snk_n), .SINK_POWER_ENABLE_OE_OUT(snk_oe),
    .SOURCE_POWER_ENABLE_N_OUT(src_n), .SOURCE_POWER_ENABLE_OE_OUT(src_oe),
    .ORIENTATION_OUT(ori), .ORIENTATION_OE_OUT(ori_oe), .VCONN_CC1_OUT(vc1),
    .VCONN_CC2_OUT(vc2), .SINK_CURRENT_OUT(cur), .SOFT_RESET_REQ_OUT(srq));
  // ****
  // Tasks
  // ****
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, input logic nt, input logic [31:0] e, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    sel <= s;
    if (!w) exp_q.push_back({nt, e});
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000, 4'hF, 1'b1, e, q0);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    wb(1'b1, a, d, s, 1'b0, 32'h0000_0000, q0);
  endtask : wr
  function automatic logic [31:0] pins();
    return {25'h000_0000, src_oe, snk_oe, ori_oe, vc1, vc2, cur};
  endfunction : pins
  // Wait spans one whole toggle phase, so either unattached state is met
  task automatic attach(input logic [2:0] a, input logic [2:0] b);
    lag <= 4'($urandom_range(0, 15));
    cc1_req <= a;
    cc2_req <= b;
    repeat (2060) @(posedge clk);
  endtask : attach
  task automatic detach();
    cc1_req <= 3'h0;
    cc2_req <= 3'h0;
    repeat (30) @(posedge clk);
    check(pins(), 32'h0000_0000);
  endtask : detach
  task automatic run(input logic [23:0] c);
    attach(c[22:20], c[18:16]);
    rd(8'h0E, {24'h00_0000, c[15:8]});
    check(pins(), {24'h00_0000, c[7:0]});
    detach();
  endtask : run
  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask : done
  // ****
  // Checking and sequence
  // ****
  always @(posedge clk) begin
    if (srq === 1'b1) srq_seen <= 1'b1;
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      if (exp_q[0][32]) check(dat_r, exp_q[0][31:0]);
      void'(exp_q.pop_front());
    end
  end
  initial begin
    repeat (70000) @(posedge clk);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
  end
  initial begin
    void'($urandom(57488));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h0C, 32'h0000_0007);
    rd(8'h18, 32'h0000_0004);
    rd(8'h1E, 32'h0000_0000);
    rd(8'h20, 32'h0000_0001);
    rd(8'h22, 32'h0000_F757);
    rd(8'h23, 32'h0000_0000);
    rd(8'h25, 32'h0000_000A);
    rd(8'h28, 32'h0000_0003);
    rd(8'h2E, 32'h0000_0004);
    rd(8'h30, 32'h0000_0000);
    rd(8'hF0, 32'h0000_0000);
    rd(8'h0E, 32'h0000_0000);
    done("defaults");
    wb(1'b0, 8'h11, 32'h0000_0000, 4'hF, 1'b0, 32'h0000_0000, q1);
    repeat (1997) @(posedge clk);
    wb(1'b0, 8'h11, 32'h0000_0000, 4'hF, 1'b0, 32'h0000_0000, q0);
    check(q0 | q1, 32'h0000_0001);
    check(q0 ^ q1, 32'h0000_0001);
    done("idle toggle");
    rv = 4'($urandom_range(0, 15));
    wr(8'h25, {28'h000_0000, rv}, 4'hF);
    rd(8'h25, {28'h000_0000, rv});
    wr(8'h25, {28'h000_0000, ~rv}, 4'hE);
    rd(8'h25, {28'h000_0000, rv});
    wr(8'hF0, 32'hFFFF_FFFF, 4'hF);
    rd(8'hF0, 32'h0000_0000);
    wr(8'h23, 32'h0000_0002, 4'hF);
    repeat (4) @(posedge clk);
    check({31'h0000_0000, srq_seen}, 32'h0000_0000);
    wr(8'h23, 32'h0000_0001, 4'hF);
    wr(8'h23, 32'h0000_0003, 4'hF);
    repeat (4) @(posedge clk);
    check({31'h0000_0000, srq_seen}, 32'h0000_0001);
    done("registers");
    for (int i = 0; i < 17; i++) run(CASES[i]);
    done("dual role");
    wr(8'h28, 32'h0000_0001, 4'hF);
    rd(8'h28, 32'h0000_0001);
    for (int i = 17; i < 20; i++) run(CASES[i]);
    wr(8'h28, 32'h0000_0003, 4'hF);
    done("sink only");
    attach(3'h3, 3'h0);
    bus_ok <= 1'b0;
    repeat (6) @(posedge clk);
    check({31'h0000_0000, snk_oe}, 32'h0000_0000);
    bus_ok <= 1'b1;
    repeat (6) @(posedge clk);
    check({31'h0000_0000, snk_oe}, 32'h0000_0001);
    detach();
    attach(3'h2, 3'h0);
    hv_p <= 1'b1;
    hv_ov <= 1'b1;
    repeat (6) @(posedge clk);
    check({31'h0000_0000, src_oe}, 32'h0000_0000);
    hv_ov <= 1'b0;
    repeat (6) @(posedge clk);
    check({31'h0000_0000, src_oe}, 32'h0000_0001);
    en <= 1'b0;
    bus_ok <= 1'b0;
    repeat (6) @(posedge clk);
    check({31'h0000_0000, src_oe}, 32'h0000_0001);
    en <= 1'b1;
    repeat (6) @(posedge clk);
    check({31'h0000_0000, src_oe}, 32'h0000_0000);
    done("faults");
    print_verdict();
  end
endmodule : test_tcpp_top
